// file: logic/rac_cmd_parser.sv
// What this block does
// R1: Mode item query-only, replies '0' local '1' remote
// R2: Local mode answers queries, refuses all sets
// R3: Gain set takes signed five-character field, short ack
// R4: Gain reply: sign, two digits, point, digit
// R5: Gain set accepted only +10.0 to +60.0
// R6: Level query-only, '<' below -60.0 else '='
// R7: Level sign always '-', clamped 60.0 below limit
// R8: Voltage set takes signed five-character field, short ack
// R9: Voltage reply signed; set within min..max tracking
// R10: Title set carries exactly 32 characters, short ack
// R11: Title query returns code and stored title
// R12: Bad or out-of-range set leaves settings unchanged
// R13: Replies echo prefix and three-letter code
//
// The address map and register access over Avalon-MM were chosen for this implementation.
`include "rac_consts.svh"
`default_nettype none
module rac_cmd_parser #(
  parameter int TITLE_LEN = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [9:0] rfLevelMag,
  output logic signed [10:0] rfGain,
  output logic signed [10:0] refVoltage
);
  localparam int RESP_MAX = TITLE_LEN + 4;

  rac_field_if fi ();
  rac_field_conv u_conv (.fi(fi));

  rac_pkg::rac_state_t st_q;
  rac_pkg::rac_item_t item_q, itemNew;
  logic waitreq_q;
  logic [31:0] rdata_q;
  logic [7:0] prefix_q;
  logic [15:0] code_q;
  logic [5:0] cnt_q, fieldNeed;
  logic [7:0] fieldMem [0:TITLE_LEN-1];
  logic [7:0] titleMem [0:TITLE_LEN-1];
  logic [7:0] respMem [0:RESP_MAX-1];
  logic [5:0] respLen_q, rdPtr_q;
  logic signed [10:0] gain_q, vref_q, minV_q, maxV_q;
  logic remote_q, reject_q;
  logic [TITLE_LEN-1:0] titleOk;
  logic doWr, doRd, byteIn, isQuery, setOk, accept, below, respAvail;
  logic [7:0] inByte;
  logic [9:0] levelShown;

  assign avs_waitrequest = waitreq_q;
  assign avs_readdata = rdata_q;
  assign rfGain = gain_q;
  assign refVoltage = vref_q;

  // An access completes in the cycle where waitrequest is low
  assign doWr = avs_write && !waitreq_q;
  assign doRd = avs_read && !waitreq_q;
  assign byteIn = doWr && (avs_address == `RAC_OFS_CMD);
  assign inByte = avs_writedata[7:0];
  assign respAvail = rdPtr_q < respLen_q;
  assign isQuery = prefix_q == `RAC_CH_QUERY;
  assign below = rfLevelMag > `RAC_LEVEL_LIMIT;
  assign levelShown = below ? `RAC_LEVEL_LIMIT : rfLevelMag; // R7

  // One wait state per access; read data is set up in the wait cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      waitreq_q <= 1'b1;
    end else if ((avs_read || avs_write) && waitreq_q) begin
      waitreq_q <= 1'b0;
    end else begin
      waitreq_q <= 1'b1;
    end
  end

  // Read mux; unmapped offsets read as zero
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= 32'h0;
    end else if (avs_read && waitreq_q) begin
      case (avs_address)
        `RAC_OFS_RESP: rdata_q <= {23'h0, respAvail, respMem[rdPtr_q]};
        `RAC_OFS_STATUS: rdata_q <= {28'h0, remote_q,
                                     st_q != rac_pkg::ST_IDLE, reject_q,
                                     respAvail};
        `RAC_OFS_CTRL: rdata_q <= {31'h0, remote_q};
        `RAC_OFS_MINV: rdata_q <= 32'(minV_q);
        `RAC_OFS_MAXV: rdata_q <= 32'(maxV_q);
        default: rdata_q <= 32'h0;
      endcase
    end
  end

  // Control registers written by software
  always_ff @(posedge clk) begin
    if (rst) begin
      remote_q <= `RAC_REMOTE_RESET;
      minV_q <= `RAC_MINV_RESET;
      maxV_q <= `RAC_MAXV_RESET;
    end else if (doWr) begin
      case (avs_address)
        `RAC_OFS_CTRL: remote_q <= avs_writedata[`RAC_CTRL_REMOTE_BIT];
        `RAC_OFS_MINV: minV_q <= avs_writedata[10:0];
        `RAC_OFS_MAXV: maxV_q <= avs_writedata[10:0];
        default: ;
      endcase
    end
  end

  // Item lookup from the two stored letters and the arriving third
  always_comb begin
    case ({code_q, inByte})
      `RAC_CODE_MODE: itemNew = rac_pkg::IT_MODE;
      `RAC_CODE_GAIN: itemNew = rac_pkg::IT_GAIN;
      `RAC_CODE_LEVEL: itemNew = rac_pkg::IT_LEVEL;
      `RAC_CODE_VREF: itemNew = rac_pkg::IT_VREF;
      `RAC_CODE_TITLE: itemNew = rac_pkg::IT_TITLE;
      default: itemNew = rac_pkg::IT_NONE;
    endcase
    case (itemNew)
      rac_pkg::IT_GAIN: fieldNeed = `RAC_NUM_LEN; // R3
      rac_pkg::IT_VREF: fieldNeed = `RAC_NUM_LEN; // R8
      rac_pkg::IT_TITLE: fieldNeed = `RAC_TITLE_LEN; // R10
      default: fieldNeed = 6'd0;
    endcase
  end

  // Parser: prefix, three letters, then the set field if any
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= rac_pkg::ST_IDLE;
      prefix_q <= 8'h0;
      code_q <= 16'h0;
      item_q <= rac_pkg::IT_NONE;
      cnt_q <= 6'd0;
    end else begin
      case (st_q)
        rac_pkg::ST_IDLE: begin
          // Stray bytes between commands are dropped
          if (byteIn && (inByte == `RAC_CH_QUERY ||
                         inByte == `RAC_CH_SET)) begin // R13
            prefix_q <= inByte;
            cnt_q <= 6'd0;
            st_q <= rac_pkg::ST_CODE;
          end
        end
        rac_pkg::ST_CODE: begin
          if (byteIn) begin
            // Third letter is not shifted in: the reply echoes all three
            code_q <= (cnt_q == 6'd2) ? code_q : {code_q[7:0], inByte};
            cnt_q <= cnt_q + 6'd1;
            if (cnt_q == 6'd2) begin
              item_q <= itemNew;
              cnt_q <= 6'd0;
              // Query-only items and unknown codes take no field
              if (isQuery || fieldNeed == 6'd0) begin // R1 R6
                st_q <= rac_pkg::ST_EXEC;
              end else begin
                st_q <= rac_pkg::ST_FIELD;
              end
            end
          end
        end
        rac_pkg::ST_FIELD: begin
          if (byteIn) begin
            cnt_q <= cnt_q + 6'd1;
            if (cnt_q == fieldNeedOf(item_q) - 6'd1) begin
              st_q <= rac_pkg::ST_EXEC;
            end
          end
        end
        rac_pkg::ST_EXEC: st_q <= rac_pkg::ST_IDLE;
        default: st_q <= rac_pkg::ST_IDLE;
      endcase
    end
  end

  function automatic logic [5:0] fieldNeedOf(input rac_pkg::rac_item_t it);
    case (it)
      rac_pkg::IT_TITLE: fieldNeedOf = `RAC_TITLE_LEN;
      default: fieldNeedOf = `RAC_NUM_LEN;
    endcase
  endfunction

  // Field bytes land in order; no reset needed for data storage
  always_ff @(posedge clk) begin
    if (st_q == rac_pkg::ST_FIELD && byteIn) begin
      fieldMem[cnt_q[4:0]] <= inByte;
    end
  end

  // Printable check per title character; spaces are allowed
  genvar g;
  generate
    for (g = 0; g < TITLE_LEN; g++) begin : gTitle
      assign titleOk[g] = (fieldMem[g] >= `RAC_CH_SPACE) &&
                          (fieldMem[g] <= `RAC_CH_TILDE); // R10
    end
  endgenerate

  // Numeric field view and encoder source
  assign fi.fieldChars = {fieldMem[0], fieldMem[1], fieldMem[2],
                          fieldMem[3], fieldMem[4]};
  always_comb begin
    case (item_q)
      rac_pkg::IT_LEVEL: fi.encMag = levelShown;
      rac_pkg::IT_GAIN: fi.encMag = gain_q[10] ? 10'(-gain_q) :
                                                 gain_q[9:0];
      default: fi.encMag = vref_q[10] ? 10'(-vref_q) : vref_q[9:0];
    endcase
  end

  // Acceptance; local mode refuses every set
  always_comb begin
    case (item_q)
      rac_pkg::IT_GAIN: setOk = fi.fieldOk &&
                                (fi.fieldVal >= `RAC_GAIN_MIN) &&
                                (fi.fieldVal <= `RAC_GAIN_MAX); // R5
      rac_pkg::IT_VREF: setOk = fi.fieldOk && (fi.fieldVal >= minV_q) &&
                                (fi.fieldVal <= maxV_q); // R9
      rac_pkg::IT_TITLE: setOk = &titleOk;
      default: setOk = 1'b0;
    endcase
    accept = isQuery ? (item_q != rac_pkg::IT_NONE) :
                       (remote_q && setOk); // R2 R12
  end

  // Settings change only on an accepted set
  always_ff @(posedge clk) begin
    if (rst) begin
      gain_q <= `RAC_GAIN_RESET;
      vref_q <= `RAC_VREF_RESET;
    end else if (st_q == rac_pkg::ST_EXEC && accept && !isQuery) begin
      if (item_q == rac_pkg::IT_GAIN) begin
        gain_q <= fi.fieldVal; // R3
      end
      if (item_q == rac_pkg::IT_VREF) begin
        vref_q <= fi.fieldVal; // R8
      end
    end
  end

  // Title store, reset to all spaces
  always_ff @(posedge clk) begin
    for (int i = 0; i < TITLE_LEN; i++) begin
      if (rst) begin
        titleMem[i] <= `RAC_CH_SPACE;
      end else if (st_q == rac_pkg::ST_EXEC && accept && !isQuery &&
                   item_q == rac_pkg::IT_TITLE) begin
        titleMem[i] <= fieldMem[i]; // R10
      end
    end
  end

  // Reply composed in one cycle; a refused command leaves no reply
  always_ff @(posedge clk) begin
    if (st_q == rac_pkg::ST_EXEC && accept) begin
      respMem[0] <= prefix_q; // R13
      respMem[1] <= code_q[15:8];
      respMem[2] <= code_q[7:0];
      respMem[3] <= codeLast(item_q);
      if (isQuery) begin
        case (item_q)
          rac_pkg::IT_MODE:
            respMem[4] <= remote_q ? `RAC_CH_ONE : `RAC_CH_ZERO; // R1
          rac_pkg::IT_LEVEL: begin
            respMem[4] <= below ? `RAC_CH_LESS : `RAC_CH_EQUAL; // R6
            respMem[5] <= `RAC_CH_MINUS; // R7
            respMem[6] <= fi.encDigits[23:16];
            respMem[7] <= fi.encDigits[15:8];
            respMem[8] <= `RAC_CH_POINT;
            respMem[9] <= fi.encDigits[7:0];
          end
          rac_pkg::IT_GAIN, rac_pkg::IT_VREF: begin
            respMem[4] <= ((item_q == rac_pkg::IT_GAIN) ? gain_q[10] :
                           vref_q[10]) ? `RAC_CH_MINUS : `RAC_CH_PLUS;
            respMem[5] <= fi.encDigits[23:16]; // R4 R9
            respMem[6] <= fi.encDigits[15:8];
            respMem[7] <= `RAC_CH_POINT;
            respMem[8] <= fi.encDigits[7:0];
          end
          rac_pkg::IT_TITLE: begin
            for (int i = 0; i < TITLE_LEN; i++) begin
              respMem[i + 4] <= titleMem[i]; // R11
            end
          end
          default: ;
        endcase
      end
    end
  end

  // The code register holds only two letters; recover the third
  function automatic logic [7:0] codeLast(input rac_pkg::rac_item_t it);
    case (it)
      rac_pkg::IT_MODE: codeLast = 8'h4d;
      rac_pkg::IT_GAIN: codeLast = 8'h47;
      rac_pkg::IT_VREF: codeLast = 8'h56;
      default: codeLast = 8'h4c;
    endcase
  endfunction

  // Reply length and read pointer; a new reply replaces the old one
  always_ff @(posedge clk) begin
    if (rst) begin
      respLen_q <= 6'd0;
      rdPtr_q <= 6'd0;
    end else if (st_q == rac_pkg::ST_EXEC) begin
      rdPtr_q <= 6'd0;
      if (!accept) begin
        respLen_q <= 6'd0; // R12
      end else if (!isQuery) begin
        respLen_q <= `RAC_ACK_LEN; // R3 R8 R10
      end else begin
        case (item_q)
          rac_pkg::IT_MODE: respLen_q <= 6'd5;
          rac_pkg::IT_LEVEL: respLen_q <= 6'd10;
          rac_pkg::IT_TITLE: respLen_q <= 6'(RESP_MAX);
          default: respLen_q <= 6'd9;
        endcase
      end
    end else if (doRd && avs_address == `RAC_OFS_RESP && respAvail) begin
      rdPtr_q <= rdPtr_q + 6'd1;
    end
  end

  // Outcome of the last command, for software to poll
  always_ff @(posedge clk) begin
    if (rst) begin
      reject_q <= 1'b0;
    end else if (st_q == rac_pkg::ST_EXEC) begin
      reject_q <= !accept;
    end
  end

  a_wait_one_state: assert property (@(posedge clk) disable iff (rst)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("access not answered after one wait state");
  a_local_no_set: assert property (@(posedge clk) disable iff (rst) // R2
    st_q == rac_pkg::ST_EXEC && !isQuery && !remote_q
    |=> $stable(rfGain) && $stable(refVoltage) && respLen_q == 6'd0)
    else $error("set took effect in local mode");
  a_gain_in_range: assert property (@(posedge clk) disable iff (rst) // R5
    rfGain >= `RAC_GAIN_MIN && rfGain <= `RAC_GAIN_MAX)
    else $error("gain outside accepted range");
  a_mode_reply: assert property (@(posedge clk) disable iff (rst) // R1
    st_q == rac_pkg::ST_EXEC && isQuery && item_q == rac_pkg::IT_MODE
    |=> respLen_q == 6'd5 &&
        respMem[4] == ($past(remote_q) ? `RAC_CH_ONE : `RAC_CH_ZERO))
    else $error("mode reply wrong");
  a_level_qual: assert property (@(posedge clk) disable iff (rst) // R6
    st_q == rac_pkg::ST_EXEC && isQuery && item_q == rac_pkg::IT_LEVEL
    |=> respMem[4] == ($past(below) ? `RAC_CH_LESS : `RAC_CH_EQUAL))
    else $error("level qualifier wrong");
  a_level_clamp: assert property (@(posedge clk) disable iff (rst) // R7
    st_q == rac_pkg::ST_EXEC && isQuery && item_q == rac_pkg::IT_LEVEL &&
    below |=> respMem[5] == `RAC_CH_MINUS && respMem[6] == 8'h36 &&
              respMem[7] == `RAC_CH_ZERO && respMem[9] == `RAC_CH_ZERO)
    else $error("level below limit not shown as 60.0");
  a_gain_format: assert property (@(posedge clk) disable iff (rst) // R4
    st_q == rac_pkg::ST_EXEC && isQuery && item_q == rac_pkg::IT_GAIN
    |=> respLen_q == 6'd9 && respMem[7] == `RAC_CH_POINT &&
        respMem[4] == `RAC_CH_PLUS)
    else $error("gain reply format wrong");
  a_vref_bounds: assert property (@(posedge clk) disable iff (rst) // R9
    $changed(refVoltage) |-> refVoltage >= $past(minV_q) &&
                             refVoltage <= $past(maxV_q))
    else $error("voltage accepted outside tracking limits");
  a_set_ack: assert property (@(posedge clk) disable iff (rst) // R13
    st_q == rac_pkg::ST_EXEC && !isQuery && accept
    |=> respLen_q == `RAC_ACK_LEN && respMem[0] == `RAC_CH_SET)
    else $error("set acknowledge wrong");
  a_title_reply: assert property (@(posedge clk) disable iff (rst) // R11
    st_q == rac_pkg::ST_EXEC && isQuery && item_q == rac_pkg::IT_TITLE
    |=> respLen_q == 6'd36 && respMem[4] == titleMem[0] &&
        respMem[RESP_MAX-1] == titleMem[TITLE_LEN-1])
    else $error("title reply length wrong");
  a_reject_keeps: assert property (@(posedge clk) disable iff (rst) // R12
    st_q == rac_pkg::ST_EXEC && !accept
    |=> $stable(rfGain) && $stable(refVoltage) && reject_q)
    else $error("rejected command changed state");
endmodule
`default_nettype wire

// file: logic/rac_consts.svh
`ifndef RAC_CONSTS_SVH
`define RAC_CONSTS_SVH

// Register byte offsets on the slave port
`define RAC_OFS_CMD 5'h00
`define RAC_OFS_RESP 5'h04
`define RAC_OFS_STATUS 5'h08
`define RAC_OFS_CTRL 5'h0c
`define RAC_OFS_MINV 5'h10
`define RAC_OFS_MAXV 5'h14

// Field positions
`define RAC_RESP_VALID_BIT 8
`define RAC_ST_AVAIL_BIT 0
`define RAC_ST_REJECT_BIT 1
`define RAC_ST_BUSY_BIT 2
`define RAC_ST_REMOTE_BIT 3
`define RAC_CTRL_REMOTE_BIT 0

// Reset values; gain and voltages in signed tenths, remote as a single bit
`define RAC_GAIN_RESET 11'sd100
`define RAC_VREF_RESET 11'sd0
`define RAC_MINV_RESET 11'sd0
`define RAC_MAXV_RESET 11'sd100
`define RAC_REMOTE_RESET 1'b1

// Limits in tenths
`define RAC_GAIN_MIN 11'sd100
`define RAC_GAIN_MAX 11'sd600
`define RAC_LEVEL_LIMIT 10'd600

// Character codes
`define RAC_CH_QUERY 8'h3f
`define RAC_CH_SET 8'h24
`define RAC_CH_PLUS 8'h2b
`define RAC_CH_MINUS 8'h2d
`define RAC_CH_POINT 8'h2e
`define RAC_CH_LESS 8'h3c
`define RAC_CH_EQUAL 8'h3d
`define RAC_CH_ZERO 8'h30
`define RAC_CH_ONE 8'h31
`define RAC_CH_SPACE 8'h20
`define RAC_CH_TILDE 8'h7e

// Three-letter item codes
`define RAC_CODE_MODE 24'h52454d
`define RAC_CODE_GAIN 24'h524647
`define RAC_CODE_LEVEL 24'h52464c
`define RAC_CODE_VREF 24'h524656
`define RAC_CODE_TITLE 24'h52544c

// Lengths
`define RAC_NUM_LEN 6'd5
`define RAC_TITLE_LEN 6'd32
`define RAC_ACK_LEN 6'd4

`endif

// file: logic/rac_field_conv.sv
`include "rac_consts.svh"
`default_nettype none
module rac_field_conv (
  rac_field_if.conv fi
);
  logic [7:0] c0, c1, c2, c3, c4;
  logic [9:0] mag;
  logic [3:0] hund, tens, ones;

  // Split the five-character signed field, first character highest
  assign c0 = fi.fieldChars[39:32];
  assign c1 = fi.fieldChars[31:24];
  assign c2 = fi.fieldChars[23:16];
  assign c3 = fi.fieldChars[15:8];
  assign c4 = fi.fieldChars[7:0];

  function automatic logic isDigit(input logic [7:0] c);
    isDigit = (c >= `RAC_CH_ZERO) && (c <= 8'h39);
  endfunction

  // Shape check: sign, digit, digit, point, digit
  assign fi.fieldOk = ((c0 == `RAC_CH_PLUS) || (c0 == `RAC_CH_MINUS)) &&
                      isDigit(c1) && isDigit(c2) &&
                      (c3 == `RAC_CH_POINT) && isDigit(c4);

  // Value in tenths; only meaningful while fieldOk is high
  assign mag = 10'(c1[3:0]) * 10'd100 + 10'(c2[3:0]) * 10'd10 +
               10'(c4[3:0]);
  assign fi.fieldVal = (c0 == `RAC_CH_MINUS) ? -$signed({1'b0, mag}) :
                       $signed({1'b0, mag});

  // Encoder to three ASCII digits, most significant first
  assign hund = 4'(fi.encMag / 10'd100);
  assign tens = 4'((fi.encMag / 10'd10) % 10'd10);
  assign ones = 4'(fi.encMag % 10'd10);
  assign fi.encDigits = {4'h3, hund, 4'h3, tens, 4'h3, ones};
endmodule
`default_nettype wire

// file: logic/rac_field_if.sv
`default_nettype none
interface rac_field_if;
  logic [39:0] fieldChars;
  logic fieldOk;
  logic signed [10:0] fieldVal;
  logic [9:0] encMag;
  logic [23:0] encDigits;
  modport conv (input fieldChars, input encMag,
                output fieldOk, output fieldVal, output encDigits);
  modport user (output fieldChars, output encMag,
                input fieldOk, input fieldVal, input encDigits);
endinterface
`default_nettype wire

// file: logic/rac_pkg.sv
`default_nettype none
package rac_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CODE = 2'b01,
    ST_FIELD = 2'b10,
    ST_EXEC = 2'b11
  } rac_state_t;

  typedef enum logic [2:0] {
    IT_NONE = 3'b000,
    IT_MODE = 3'b001,
    IT_GAIN = 3'b010,
    IT_LEVEL = 3'b011,
    IT_VREF = 3'b100,
    IT_TITLE = 3'b101
  } rac_item_t;
endpackage
`default_nettype wire

// file: tb/rac_host_model.sv
`include "rac_consts.svh"
`default_nettype none
module rac_host_model (
  input wire logic clk,
  output logic [4:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  timeunit 1ns;
  timeprecision 1ps;

  // Bus idle from time zero
  initial begin
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
  end

  // One access; request held until the edge that sees waitrequest low
  task automatic acc(input logic wr, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    // Waitrequest is looked at on rising edges only; that edge ends it
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    r = avs_readdata; // Taken at the completing edge
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // Prefix, three-letter code, then the field, one byte per write
  task automatic cmd(input logic [7:0] p, input logic [23:0] c,
                     input logic [7:0] f[$]);
    logic [31:0] r;
    acc(1'b1, `RAC_OFS_CMD, {24'h0, p}, r);
    for (int i = 2; i >= 0; i--) begin
      acc(1'b1, `RAC_OFS_CMD, {24'h0, c[8*i+:8]}, r);
    end
    foreach (f[i]) acc(1'b1, `RAC_OFS_CMD, {24'h0, f[i]}, r);
  endtask

  // Drain reply bytes until the valid flag drops; bounded for safety
  task automatic reply(output logic [7:0] q[$]);
    logic [31:0] r;
    q = {};
    for (int n = 0; n < 64; n++) begin
      acc(1'b0, `RAC_OFS_RESP, 32'h0, r);
      if (r[`RAC_RESP_VALID_BIT] !== 1'b1) break;
      q.push_back(r[7:0]);
    end
  endtask
endmodule
`default_nettype wire

// file: tb/tb_top.sv
`include "rac_consts.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef logic [7:0] rac_bytes_t[$];
  logic clk;
  logic rst;
  logic [4:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [9:0] rfLevelMag;
  logic signed [10:0] rfGain;
  logic signed [10:0] refVoltage;
  int miscompares;
  int nCompared;

  rac_cmd_parser #(.TITLE_LEN(32)) i_rac_cmd_parser (
    .clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rfLevelMag(rfLevelMag),
    .rfGain(rfGain), .refVoltage(refVoltage));
  rac_host_model i_rac_host_model (
    .clk(clk), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  // Free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Reply text helpers: dd.d digits, signed value, header, set ack
  function automatic rac_bytes_t digs(int a);
    rac_bytes_t q;
    q = {8'h30 + 8'(a / 100), 8'h30 + 8'(a / 10 % 10), `RAC_CH_POINT,
         8'h30 + 8'(a % 10)};
    return q;
  endfunction
  function automatic rac_bytes_t num(int v);
    rac_bytes_t q;
    q = {(v < 0) ? `RAC_CH_MINUS : `RAC_CH_PLUS};
    q = {q, digs(v < 0 ? -v : v)};
    return q;
  endfunction
  function automatic rac_bytes_t hdr(logic [7:0] p, logic [23:0] c);
    rac_bytes_t q;
    q = {p, c[23:16], c[15:8], c[7:0]};
    return q;
  endfunction
  function automatic rac_bytes_t ack(bit ok, logic [23:0] c);
    rac_bytes_t q;
    if (ok) q = hdr(`RAC_CH_SET, c);
    return q;
  endfunction

  // Single comparison point; counts every compare
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // Send a command, drain the reply and compare; empty means refused
  task automatic run(input logic [7:0] p, input logic [23:0] c,
                     input rac_bytes_t f, input rac_bytes_t e);
    rac_bytes_t q;
    logic [31:0] s;
    i_rac_host_model.cmd(p, c, f);
    i_rac_host_model.reply(q);
    i_rac_host_model.acc(1'b0, `RAC_OFS_STATUS, 32'h0, s);
    chk(32'(q.size()), 32'(e.size()));
    foreach (e[i]) if (i < q.size()) chk(q[i], e[i]);
    chk(s[`RAC_ST_REJECT_BIT], e.size() == 0);
    chk(s[`RAC_ST_AVAIL_BIT], 1'b0);
    chk(s[`RAC_ST_BUSY_BIT], 1'b0);
  endtask

  task automatic stop_test();
    $display("Compared %0d, mismatches %0d", nCompared, miscompares);
    if (miscompares == 0 && nCompared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    #400000;
    miscompares++;
    stop_test();
  end

  initial begin
    rac_bytes_t none;
    rac_bytes_t f;
    rac_bytes_t title;
    logic [31:0] rd;
    int gv[5] = '{100, 600, 99, 601, -200};
    int lv[4] = '{0, 600, 601, 999};
    int xv[4] = '{-50, 120, -51, 121};
    int v;
    int gainExp;
    int vrefExp;
    bit ok;
    miscompares = 0;
    nCompared = 0;
    rst = 1'b1;
    rfLevelMag = 10'h000;
    void'($urandom(32'h22aff0ba));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    gainExp = 100;
    vrefExp = 0;
    // Reset values and an unmapped address
    chk(rfGain, gainExp);
    chk(refVoltage, vrefExp);
    i_rac_host_model.acc(1'b0, `RAC_OFS_CTRL, 32'h0, rd);
    chk(rd[0], 1'b1);
    i_rac_host_model.acc(1'b0, `RAC_OFS_MAXV, 32'h0, rd);
    chk(rd[10:0], 11'h064);
    i_rac_host_model.acc(1'b1, 5'h18, 32'hffffffff, rd);
    i_rac_host_model.acc(1'b0, 5'h18, 32'h0, rd);
    chk(rd, 32'h0);
    $display("test reset done");
    // Mode reply tracks the remote bit; local refuses sets only
    run(`RAC_CH_QUERY, `RAC_CODE_MODE, none,
        {hdr(`RAC_CH_QUERY, `RAC_CODE_MODE), `RAC_CH_ONE});
    i_rac_host_model.acc(1'b1, `RAC_OFS_CTRL, 32'h0, rd);
    run(`RAC_CH_QUERY, `RAC_CODE_MODE, none,
        {hdr(`RAC_CH_QUERY, `RAC_CODE_MODE), `RAC_CH_ZERO});
    run(`RAC_CH_SET, `RAC_CODE_GAIN, num(300), none);
    run(`RAC_CH_QUERY, `RAC_CODE_GAIN, none,
        {hdr(`RAC_CH_QUERY, `RAC_CODE_GAIN), num(gainExp)});
    chk(rfGain, gainExp);
    i_rac_host_model.acc(1'b1, `RAC_OFS_CTRL, 32'h1, rd);
    run(`RAC_CH_SET, `RAC_CODE_MODE, {`RAC_CH_ONE}, none);
    run(`RAC_CH_SET, `RAC_CODE_LEVEL, num(100), none);
    run(`RAC_CH_QUERY, 24'h515151, none, none);
    $display("test mode done");
    // Gain: both bounds, just outside them, negative, random in range
    for (int i = 0; i < 8; i++) begin
      v = (i < 5) ? gv[i] : 100 + $urandom_range(500);
      ok = v >= 100 && v <= 600;
      if (ok) gainExp = v;
      run(`RAC_CH_SET, `RAC_CODE_GAIN, num(v),
          ack(ok, `RAC_CODE_GAIN));
      chk(rfGain, gainExp);
      run(`RAC_CH_QUERY, `RAC_CODE_GAIN, none,
          {hdr(`RAC_CH_QUERY, `RAC_CODE_GAIN), num(gainExp)});
    end
    f = {`RAC_CH_PLUS, 8'h32, 8'h78, `RAC_CH_POINT, 8'h30};
    run(`RAC_CH_SET, `RAC_CODE_GAIN, f, none);
    chk(rfGain, gainExp);
    $display("test gain done");
    // Level: zero, at the limit, just below it, extremes, random
    for (int i = 0; i < 6; i++) begin
      v = (i < 4) ? lv[i] : $urandom_range(999);
      @(posedge clk);
      rfLevelMag <= 10'(v);
      ok = v > 600;
      run(`RAC_CH_QUERY, `RAC_CODE_LEVEL, none,
          {hdr(`RAC_CH_QUERY, `RAC_CODE_LEVEL),
           ok ? `RAC_CH_LESS : `RAC_CH_EQUAL, `RAC_CH_MINUS,
           digs(ok ? 600 : v)});
    end
    $display("test level done");
    // Voltage window -5.0 .. +12.0, edges and random inside
    i_rac_host_model.acc(1'b1, `RAC_OFS_MINV, 32'hffffffce, rd);
    i_rac_host_model.acc(1'b1, `RAC_OFS_MAXV, 32'h00000078, rd);
    for (int i = 0; i < 6; i++) begin
      v = (i < 4) ? xv[i] : $urandom_range(170) - 50;
      ok = v >= -50 && v <= 120;
      if (ok) vrefExp = v;
      run(`RAC_CH_SET, `RAC_CODE_VREF, num(v),
          ack(ok, `RAC_CODE_VREF));
      chk(refVoltage, vrefExp);
      run(`RAC_CH_QUERY, `RAC_CODE_VREF, none,
          {hdr(`RAC_CH_QUERY, `RAC_CODE_VREF), num(vrefExp)});
    end
    $display("test voltage done");
    // Title: reset text, random 32 characters, then a refused one
    for (int i = 0; i < 32; i++) title.push_back(`RAC_CH_SPACE);
    run(`RAC_CH_QUERY, `RAC_CODE_TITLE, none,
        {hdr(`RAC_CH_QUERY, `RAC_CODE_TITLE), title});
    foreach (title[i]) title[i] = 8'h20 + 8'($urandom_range(94));
    run(`RAC_CH_SET, `RAC_CODE_TITLE, title,
        ack(1'b1, `RAC_CODE_TITLE));
    f = title;
    f[7] = 8'h7f;
    run(`RAC_CH_SET, `RAC_CODE_TITLE, f, none);
    run(`RAC_CH_QUERY, `RAC_CODE_TITLE, none,
        {hdr(`RAC_CH_QUERY, `RAC_CODE_TITLE), title});
    $display("test title done");
    stop_test();
  end
endmodule
`default_nettype wire
